// file: attr_cursor_params.svh
`ifndef ATTR_CURSOR_PARAMS_SVH
`define ATTR_CURSOR_PARAMS_SVH

// Extension register indices behind the indexed data port.
`define IDX_ATTR_COLOUR_CTRL   8'hC0
`define IDX_CURSOR_ATTR_CTRL   8'hC1
`define CTRL_RESET_VAL         8'h00

// Field positions of the attribute colour control register.
`define ACC_FG_ENH_BIT         0
`define ACC_PAL_BYPASS_BIT     1
`define ACC_BG_ENH_BIT         3

// Field positions of the cursor attribute control register.
`define CAC_BLINK_DIS_BIT      0
`define CAC_RATE_LSB           1
`define CAC_RATE_MSB           2
`define CAC_MODE_BIT           3
`define CAC_BORDER_INV_BIT     4
`define CAC_FORCE_BW_BIT       5

// Writable masks; reserved positions read as zero.
`define ACC_WR_MASK            8'h0B
`define CAC_WR_MASK            8'h3F

// Colour constants of the enhancement formulas.
`define COLOUR_BLACK           4'h0
`define COLOUR_LIGHT_GREY      4'h7
`define COLOUR_DARK_GREY       4'h8
`define COLOUR_WHITE           4'hF
`define INTENSITY_BIT          3

// Blink divisors in vertical syncs per code.
`define BLINK_DIV_CODE0        6'h10
`define BLINK_DIV_CODE1        6'h20
`define BLINK_DIV_CODE2        6'h08
`define BLINK_DIV_CODE3        6'h04

`endif

// file: attr_cursor_pkg.sv
package attr_cursor_pkg;

  typedef struct packed {
    logic       bg_enh;
    logic       pal_bypass;
    logic       fg_enh;
  } colour_ctrl_t;

  typedef struct packed {
    logic       force_bw;
    logic       border_inv;
    logic       invert_mode;
    logic [1:0] blink_rate;
    logic       blink_dis;
  } cursor_ctrl_t;

  typedef struct packed {
    logic [3:0] fg;
    logic [3:0] bg;
    logic       fg_on;
    logic       cursor_on;
  } pixel_in_t;

endpackage

// file: blink_gen.sv
`timescale 1ns/1ps
`include "attr_cursor_params.svh"

module blink_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       vsync_in,
  input  wire logic [1:0] rate_in,
  output logic            phase_out
);

  logic       vsync_d_r;
  logic [4:0] count_r;
  logic [5:0] div;
  logic [4:0] half;
  logic       vs_rise;

  assign vs_rise = vsync_in & ~vsync_d_r;

  // ========================================================
  // Divisor select
  // ========================================================
  // RULE8 - rate code divisors
  always_comb begin
    unique case (rate_in)
      2'b00: div = `BLINK_DIV_CODE0;
      2'b01: div = `BLINK_DIV_CODE1;
      2'b10: div = `BLINK_DIV_CODE2;
      2'b11: div = `BLINK_DIV_CODE3;
    endcase
  end

  assign half = div[5:1];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vsync_d_r <= 1'b0;
    end else begin
      vsync_d_r <= vsync_in;
    end
  end

  // RULE11 - per-frame count toggle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r   <= 5'h00;
      phase_out <= 1'b1;
    end else if (vs_rise) begin
      if (count_r + 5'h01 >= half) begin
        count_r   <= 5'h00;
        phase_out <= ~phase_out;
      end else begin
        count_r <= count_r + 5'h01;
      end
    end
  end

endmodule

// file: colour_enhance.sv
`timescale 1ns/1ps
`include "attr_cursor_params.svh"

module colour_enhance (
  input  wire logic [3:0] fg_in,
  input  wire logic [3:0] bg_in,
  input  wire logic       fg_enh_in,
  input  wire logic       bg_enh_in,
  output logic [3:0]      fg_out,
  output logic [3:0]      bg_out
);

  // RULE3 - flip intensity bit
  always_comb begin
    fg_out = fg_in;
    if (fg_enh_in && fg_in != `COLOUR_BLACK && fg_in != `COLOUR_DARK_GREY) begin
      fg_out[`INTENSITY_BIT] = ~fg_in[`INTENSITY_BIT];
    end
  end

  // RULE1 - background contrast formula
  always_comb begin
    if (bg_enh_in) begin
      bg_out = (fg_in == `COLOUR_BLACK) ? `COLOUR_LIGHT_GREY : `COLOUR_BLACK;
    end else begin
      bg_out = bg_in;
    end
  end

endmodule

// file: attribute_cursor_controls.sv
`timescale 1ns/1ps
`include "attr_cursor_params.svh"

// Contract
// RULE1 - background enhancement picks 7 or 0
// RULE2 - bypass bit skips internal palette
// RULE3 - foreground enhancement flips intensity, not 0/8
// RULE4 - software writes reserved bits as zero
// RULE5 - force black/white cursor on panel
// RULE6 - invert border colour bits
// RULE7 - cursor inverts or replaces pixels
// RULE8 - rate codes divide by 16,32,8,4
// RULE9 - blink disable holds cursor steady
// RULE10 - both registers reset zero, own index
// RULE11 - blink from vsync counter, half-divisor toggle
module attribute_cursor_controls (
  input  wire logic                      sys_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic [7:0]                index_in,
  input  wire logic                      data_wr_in,
  input  wire logic [7:0]                data_wr_val_in,
  output logic [7:0]                     data_rd_out,
  input  wire logic                      vsync_in,
  input  wire logic                      panel_active_in,
  input  wire attr_cursor_pkg::pixel_in_t pix_in,
  input  wire logic [7:0]                border_colour_in,
  output logic [7:0]                     palette_addr_out,
  output logic                           palette_bypass_out,
  output logic [7:0]                     border_colour_out,
  output logic [3:0]                     pixel_out
);

  logic                         rst_s1_r;
  logic                         rst_n_r;
  logic [7:0]                   acc_r;
  logic [7:0]                   cac_r;
  attr_cursor_pkg::colour_ctrl_t colour_ctrl;
  attr_cursor_pkg::cursor_ctrl_t cursor_ctrl;
  logic [3:0]                   fg_enh;
  logic [3:0]                   bg_enh;
  logic                         blink_phase;
  logic                         cursor_vis;
  logic [3:0]                   base_pix;
  logic [3:0]                   pix_nxt;

  // ========================================================
  // Reset release
  // ========================================================
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ========================================================
  // Indexed registers
  // ========================================================
  // RULE10 - reset and index decode
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= `CTRL_RESET_VAL;
      cac_r <= `CTRL_RESET_VAL;
    end else if (data_wr_in) begin
      // RULE4 - reserved bits dropped
      if (index_in == `IDX_ATTR_COLOUR_CTRL) begin
        acc_r <= data_wr_val_in & `ACC_WR_MASK;
      end
      if (index_in == `IDX_CURSOR_ATTR_CTRL) begin
        cac_r <= data_wr_val_in & `CAC_WR_MASK;
      end
    end
  end

  always_comb begin
    unique case (index_in)
      `IDX_ATTR_COLOUR_CTRL: data_rd_out = acc_r;
      `IDX_CURSOR_ATTR_CTRL: data_rd_out = cac_r;
      default:               data_rd_out = 8'h00;
    endcase
  end

  assign colour_ctrl.bg_enh      = acc_r[`ACC_BG_ENH_BIT];
  assign colour_ctrl.pal_bypass  = acc_r[`ACC_PAL_BYPASS_BIT];
  assign colour_ctrl.fg_enh      = acc_r[`ACC_FG_ENH_BIT];
  assign cursor_ctrl.force_bw    = cac_r[`CAC_FORCE_BW_BIT];
  assign cursor_ctrl.border_inv  = cac_r[`CAC_BORDER_INV_BIT];
  assign cursor_ctrl.invert_mode = cac_r[`CAC_MODE_BIT];
  assign cursor_ctrl.blink_rate  = cac_r[`CAC_RATE_MSB:`CAC_RATE_LSB];
  assign cursor_ctrl.blink_dis   = cac_r[`CAC_BLINK_DIS_BIT];

  // ========================================================
  // Colour path
  // ========================================================
  colour_enhance u_enh (
    .fg_in     (pix_in.fg),
    .bg_in     (pix_in.bg),
    .fg_enh_in (colour_ctrl.fg_enh),
    .bg_enh_in (colour_ctrl.bg_enh),
    .fg_out    (fg_enh),
    .bg_out    (bg_enh)
  );

  blink_gen u_blink (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n_r),
    .vsync_in  (vsync_in),
    .rate_in   (cursor_ctrl.blink_rate),
    .phase_out (blink_phase)
  );

  // RULE9 - disable forces steady
  assign cursor_vis = pix_in.cursor_on & (cursor_ctrl.blink_dis | blink_phase);

  assign base_pix = pix_in.fg_on ? fg_enh : bg_enh;

  always_comb begin
    pix_nxt = base_pix;
    if (cursor_vis) begin
      // RULE5 - black and white on panel
      if (cursor_ctrl.force_bw && panel_active_in) begin
        pix_nxt = (base_pix == `COLOUR_BLACK) ? `COLOUR_WHITE : `COLOUR_BLACK;
      // RULE7 - invert versus replace
      end else if (cursor_ctrl.invert_mode) begin
        pix_nxt = ~base_pix;
      end else begin
        pix_nxt = fg_enh;
      end
    end
  end

  // ========================================================
  // Output registers
  // ========================================================
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pixel_out          <= 4'h0;
      palette_addr_out   <= 8'h00;
      palette_bypass_out <= 1'b0;
      border_colour_out  <= 8'h00;
    end else begin
      pixel_out          <= pix_nxt;
      // RULE2 - palette bypass steering
      palette_bypass_out <= colour_ctrl.pal_bypass;
      palette_addr_out   <= {4'h0, pix_nxt};
      // RULE6 - border inversion
      border_colour_out  <= cursor_ctrl.border_inv ? ~border_colour_in : border_colour_in;
    end
  end

endmodule

// file: attr_cursor_props.sv
`timescale 1ns/1ps
module attr_cursor_props (
  input wire logic                       sys_clk_in,
  input wire logic                       reset_n_in,
  input wire logic [7:0]                 index_in,
  input wire logic                       data_wr_in,
  input wire logic [7:0]                 data_wr_val_in,
  input wire logic [7:0]                 data_rd_out,
  input wire attr_cursor_pkg::pixel_in_t pix_in,
  input wire logic [7:0]                 border_colour_in,
  input wire logic                       palette_bypass_out,
  input wire logic [7:0]                 border_colour_out,
  input wire logic [3:0]                 pixel_out
);
  // ==========
  // Properties
  logic [2:0] live_r;
  logic       c0;
  logic       c1;
  assign c0 = index_in == 8'hC0 && !data_wr_in;
  assign c1 = index_in == 8'hC1 && !data_wr_in;
  // Outputs are judged only once the internal reset copy has let go.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) live_r <= 3'h0;
    else live_r <= {live_r[1:0], 1'b1};
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!live_r[2]);
  property p_map; !(index_in inside {8'hC0, 8'hC1}) |-> data_rd_out == 8'h00; endproperty
  a_map: assert property (p_map) else $error("unmapped read not zero");
  property p_res0; index_in == 8'hC0 |-> (data_rd_out & 8'hF4) == 8'h00; endproperty
  a_res0: assert property (p_res0) else $error("reserved bits set");
  property p_res1; index_in == 8'hC1 |-> data_rd_out[7:6] == 2'h0; endproperty
  a_res1: assert property (p_res1) else $error("reserved bits set");
  property p_wr;
    data_wr_in && index_in == 8'hC1 ##1 c1 |-> data_rd_out == ($past(data_wr_val_in) & 8'h3F);
  endproperty
  a_wr: assert property (p_wr) else $error("write not read back");
  property p_byp; c0 |=> palette_bypass_out == $past(data_rd_out[1]); endproperty
  a_byp: assert property (p_byp) else $error("bypass mismatch");
  property p_bord;
    c1 |=> border_colour_out == ($past(border_colour_in) ^ {8{$past(data_rd_out[4])}});
  endproperty
  a_bord: assert property (p_bord) else $error("border mismatch");
  property p_bg;
    c0 && !pix_in.fg_on && !pix_in.cursor_on |=> pixel_out == ($past(data_rd_out[3]) ?
      (($past(pix_in.fg) == 4'h0) ? 4'h7 : 4'h0) : $past(pix_in.bg));
  endproperty
  a_bg: assert property (p_bg) else $error("background mismatch");
  property p_fg;
    c0 && pix_in.fg_on && !pix_in.cursor_on |=> pixel_out == ($past(pix_in.fg) ^
      {$past(data_rd_out[0]) && $past(pix_in.fg[2:0]) != 3'h0, 3'h0});
  endproperty
  a_fg: assert property (p_fg) else $error("foreground mismatch");
  c_wr: cover property (data_wr_in && index_in == 8'hC1);
  c_bg: cover property (c0 && data_rd_out[3] && !pix_in.fg_on);
  c_inv: cover property (c1 && data_rd_out[4]);
endmodule

bind attribute_cursor_controls attr_cursor_props props (.*);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // =====
  // Bench
  logic       sys_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [7:0] index_in = 8'h00;
  logic       data_wr_in = 1'b0;
  logic [7:0] data_wr_val_in = 8'h00;
  logic       vsync_in = 1'b0;
  logic       panel_active_in = 1'b0;
  attr_cursor_pkg::pixel_in_t pix_in = '0;
  logic [7:0] border_colour_in = 8'h5A;
  logic [7:0] data_rd_out;
  logic [7:0] palette_addr_out;
  logic       palette_bypass_out;
  logic [7:0] border_colour_out;
  logic [3:0] pixel_out;
  int         errors = 0;
  int         checks_done = 0;
  int         half [4] = '{8, 16, 4, 2};
  localparam attr_cursor_pkg::pixel_in_t cur_pix = {4'h9, 4'h3, 2'h1};
  always #4 sys_clk_in = ~sys_clk_in;
  attribute_cursor_controls dut (.*);
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    tick;
    index_in = idx;
    data_wr_val_in = val;
    data_wr_in = 1'b1;
    tick;
    data_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    tick;
    index_in = idx;
    #1;
    chk("data_rd_out", exp, data_rd_out);
  endtask
  task automatic px(input attr_cursor_pkg::pixel_in_t p, input logic [3:0] exp);
    tick;
    pix_in = p;
    tick;
    chk("pixel_out", {4'h0, exp}, {4'h0, pixel_out});
    chk("palette_addr_out", {4'h0, exp}, palette_addr_out);
  endtask
  task automatic vs(input int n);
    repeat (n) begin
      tick;
      vsync_in = 1'b1;
      tick;
      vsync_in = 1'b0;
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    #1;
    reset_n_in = 1'b1;
    repeat (3) tick;
    rd(8'hC0, 8'h00);
    rd(8'hC1, 8'h00);
    rd(8'hC7, 8'h00);
    wr(8'hC0, 8'hFF);
    rd(8'hC0, 8'h0B);
    tick;
    chk("palette_bypass_out", 8'h01, {7'h0, palette_bypass_out});
    wr(8'hC1, 8'hFF);
    rd(8'hC1, 8'h3F);
    tick;
    chk("border_colour_out", 8'hA5, border_colour_out);
    wr(8'hC0, 8'h08);
    px({4'h0, 4'h5, 2'h0}, 4'h7);
    px({4'h3, 4'h5, 2'h0}, 4'h0);
    chk("palette_bypass_out", 8'h00, {7'h0, palette_bypass_out});
    wr(8'hC0, 8'h01);
    px({4'h3, 4'h5, 2'h0}, 4'h5);
    for (int f = 0; f < 16; f++) begin
      px({f[3:0], 4'h5, 2'h2}, (f % 8 == 0) ? f[3:0] : f[3:0] ^ 4'h8);
    end
    wr(8'hC0, 8'h00);
    wr(8'hC1, 8'h09);
    px(cur_pix, 4'hC);
    chk("border_colour_out", 8'h5A, border_colour_out);
    wr(8'hC1, 8'h21);
    px(cur_pix, 4'h9);
    tick;
    panel_active_in = 1'b1;
    px(cur_pix, 4'h0);
    px({4'h9, 4'h0, 2'h1}, 4'hF);
    tick;
    panel_active_in = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(8'hC1, {5'h00, c[1:0], 1'b0});
      px(cur_pix, 4'h9);
      vs(half[c] - 1);
      px(cur_pix, 4'h9);
      vs(1);
      px(cur_pix, 4'h3);
      vs(half[c]);
      px(cur_pix, 4'h9);
    end
    wr(8'hC1, 8'h01);
    vs(8);
    px(cur_pix, 4'h9);
    summarize;
  end
endmodule
